// *** hw/motor_ctl_defs.svh ***
// constants for the stepper ramp / stop / sensor priority block
// assumes inclusion from the design, checker and bench files
`ifndef MOTOR_CTL_DEFS_SVH
`define MOTOR_CTL_DEFS_SVH
// ******************************
// register byte addresses
// ******************************
`define OFF_CTRL 12'h000
`define OFF_CFG 12'h004
`define OFF_IOC 12'h008
`define OFF_MASK_IN 12'h00C
`define OFF_EDGE_R 12'h010
`define OFF_EDGE_F 12'h014
`define OFF_ACTION 12'h018
`define OFF_ROT 12'h01C
`define OFF_RAMP 12'h020
`define OFF_STATUS 12'h024
`define OFF_IRQ_STAT 12'h028
`define OFF_IRQ_MASK 12'h02C
`define OFF_XSTEPS 12'h030
`define OFF_PERIOD 12'h034
// ******************************
// field positions
// ******************************
`define CTRL_RUN_BIT 7
`define CTRL_DIR_BIT 0
`define CFG_HARD_BIT 0
`define CFG_RUP_BIT 1
`define CFG_RDN_BIT 2
`define ACT_REV_BIT 0
`define ACT_XSTEP_BIT 1
// irq status bits
`define IRQ_SENSE_BIT 0
`define IRQ_STOP_BIT 1
`define IRQ_IGN_BIT 2
// ******************************
// reset values
// ******************************
`define RST_ROT 8'h01
`define RST_RAMP 8'h10
`define RST_XSTEPS 8'h04
`define RST_PERIOD 8'h10
`define STEPS_PER_ROT 8'h30
// slowest start period multiplier during ramps
`define RAMP_SLOW 8'h40
`endif

// *** hw/motor_ctl_pkg.sv ***
// types shared by the stepper ramp / stop / sensor priority block
// assumes motor_ctl_defs.svh sits on the include path
package motor_ctl_pkg;
    // motion phase of the motor
    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_RAMP_UP = 3'b001,
        PH_RUN = 3'b010,
        PH_XSTEP = 3'b011,
        PH_RAMP_DN = 3'b100
    } phase_t;
    // ahb-lite slave request, as sampled in the address phase
    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic hready;
    } ahb_req_t;
    // ahb-lite slave answer
    typedef struct packed {
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } ahb_rsp_t;
endpackage

// *** hw/step_timer.sv ***
// step pulse timer: one pulse every period+1 cycles while enabled
// assumes the caller holds period steady between pulses
`timescale 1ns/1ps
module step_timer (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic enable,
    input wire logic [15:0] period,
    output logic step_pulse
);
    typedef struct packed {
        logic [15:0] cnt;
        logic pulse;
    } tmr_state_t;
    tmr_state_t st_ff, nxt_st;
    // count down, pulse on wrap
    always_comb begin
        nxt_st = st_ff;
        nxt_st.pulse = 1'b0;
        if (!enable) begin
            nxt_st.cnt = period;
        end else if (st_ff.cnt == 16'h0000) begin
            nxt_st.cnt = period;
            nxt_st.pulse = 1'b1;
        end else begin
            nxt_st.cnt = st_ff.cnt - 16'h0001;
        end
    end
    // state register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
    assign step_pulse = st_ff.pulse;
endmodule // step_timer

// *** hw/motor_ctl.sv ***
// stepper ramp, stop and sensor-interrupt priority logic, ahb-lite regs
// assumes a single ahb-lite master and glitch-free sensor inputs
// What this block does
// R1 - ignore sensor interrupts while ramping up or down
// R2 - act on enabled sensor interrupts once at final speed
// R3 - only a stop request (control bit 7 cleared) alters ramps
// R4 - stop in ramp-up with hard stop: halt at once, top priority
// R5 - stop in ramp-up, no hard stop, ramp-down on: decelerate
// R6 - stop in ramp-up, neither enabled: halt at once
// R7 - stop in ramp-down with hard stop: halt, drop the ramp
// R8 - stop in ramp-down, ramp-down on: keep decelerating
// R9 - between ramps, enabled interrupt controls may change motion
// R10 - reverse-on-interrupt at speed: reverse, run rotation count
// R11 - rotations done with no interrupt: ramp down if enabled
// R12 - extra steps enabled: issue them first, then reverse
// R13 - sensor inputs are used without any debouncing
// R14 - the host supplies clean logic-level sensor signals
// R15 - registers hold single bytes, written and read singly
// R16 - pin interrupts need input mode, unmasked, edge chosen
// R17 - after a reversal restart the full rotation count
`timescale 1ns/1ps
`include "motor_ctl_defs.svh"
module motor_ctl (
    input wire logic hclk,
    input wire logic hresetn,
    input wire motor_ctl_pkg::ahb_req_t ahb_req,
    input wire logic [31:0] hwdata,
    output motor_ctl_pkg::ahb_rsp_t ahb_rsp,
    input wire logic sense_input_0,
    input wire logic sense_input_1,
    output logic [3:0] phase_out,
    output logic irq
);
    import motor_ctl_pkg::*;

    // **************************************************
    // state
    // **************************************************
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] cfg;
        logic [1:0] ioc;
        logic [1:0] mask_in;
        logic [1:0] edge_r;
        logic [1:0] edge_f;
        logic [7:0] action;
        logic [7:0] rot;
        logic [7:0] ramp;
        logic [7:0] xsteps;
        logic [7:0] period;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        // bus data phase
        logic wr_pend;
        logic [11:0] wr_addr;
        logic [31:0] rdata;
        // motion
        phase_t phase;
        logic dir;
        logic [15:0] steps_left;
        logic [7:0] ramp_pos;
        logic [7:0] xleft;
        logic [2:0] seq;
        logic [1:0] sense_prev;
        logic [3:0] coils;
    } core_state_t;
    core_state_t st_ff, nxt_st;

    logic step_pulse;
    logic [15:0] step_period;
    logic [1:0] sense_now;
    logic [1:0] sense_hit;
    logic sense_any;
    logic addr_ok;
    logic wr_en;
    logic [7:0] wbyte;
    logic stop_req;

    // **************************************************
    // helpers
    // **************************************************
    // read mux used by the data phase
    function automatic logic [7:0] reg_read(input core_state_t s,
                                            input logic [11:0] a);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            `OFF_CTRL: v = s.ctrl;
            `OFF_CFG: v = s.cfg;
            `OFF_IOC: v = {6'h00, s.ioc};
            `OFF_MASK_IN: v = {6'h00, s.mask_in};
            `OFF_EDGE_R: v = {6'h00, s.edge_r};
            `OFF_EDGE_F: v = {6'h00, s.edge_f};
            `OFF_ACTION: v = s.action;
            `OFF_ROT: v = s.rot;
            `OFF_RAMP: v = s.ramp;
            `OFF_STATUS: v = {4'h0, s.dir, s.phase};
            `OFF_IRQ_STAT: v = {5'h00, s.irq_stat};
            `OFF_IRQ_MASK: v = {5'h00, s.irq_mask};
            `OFF_XSTEPS: v = s.xsteps;
            `OFF_PERIOD: v = s.period;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // full step count for the programmed rotations
    function automatic logic [15:0] rot_steps(input logic [7:0] r);
        // widen before the product so large counts are not cut to 8 bits
        return 16'(r) * 16'(`STEPS_PER_ROT);
    endfunction

    // two-phase coil pattern from the sequence index
    function automatic logic [3:0] coil_map(input logic [2:0] i);
        logic [3:0] c;
        unique case (i[1:0])
            2'b00: c = 4'b1100;
            2'b01: c = 4'b0110;
            2'b10: c = 4'b0011;
            default: c = 4'b1001;
        endcase
        return c;
    endfunction

    // **************************************************
    // sensor edges, taken raw with no filtering
    // **************************************************
    assign sense_now = {sense_input_1, sense_input_0}; // see R13
    // qualify each pin by mode, mask and chosen edge
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            sense_hit[i] = st_ff.ioc[i] && st_ff.mask_in[i] &&
                ((st_ff.edge_r[i] && sense_now[i] && !st_ff.sense_prev[i])
                || (st_ff.edge_f[i] && !sense_now[i]
                && st_ff.sense_prev[i])); // see R16
        end
    end
    assign sense_any = |sense_hit;

    // **************************************************
    // bus decode
    // **************************************************
    assign addr_ok = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;
    assign wr_en = st_ff.wr_pend;
    assign wbyte = hwdata[7:0]; // see R15
    assign stop_req = wr_en && (st_ff.wr_addr == `OFF_CTRL)
        && !wbyte[`CTRL_RUN_BIT];

    // slower steps early in ramp-up and late in ramp-down
    assign step_period = (st_ff.phase == PH_RAMP_UP ||
        st_ff.phase == PH_RAMP_DN) ?
        16'({st_ff.period, 8'h00} >> 4) + 16'({8'h00, st_ff.ramp_pos} << 4)
        : {8'h00, st_ff.period};

    // **************************************************
    // next state
    // **************************************************
    always_comb begin
        nxt_st = st_ff;
        nxt_st.sense_prev = sense_now;
        nxt_st.wr_pend = addr_ok && ahb_req.hwrite;
        nxt_st.wr_addr = ahb_req.haddr[11:0];
        if (addr_ok && !ahb_req.hwrite) begin
            nxt_st.rdata = {24'h000000,
                reg_read(st_ff, ahb_req.haddr[11:0])}; // see R15
        end
        // register writes, one byte each
        if (wr_en) begin
            unique case (st_ff.wr_addr)
                `OFF_CTRL: nxt_st.ctrl = wbyte;
                `OFF_CFG: nxt_st.cfg = wbyte;
                `OFF_IOC: nxt_st.ioc = wbyte[1:0];
                `OFF_MASK_IN: nxt_st.mask_in = wbyte[1:0];
                `OFF_EDGE_R: nxt_st.edge_r = wbyte[1:0];
                `OFF_EDGE_F: nxt_st.edge_f = wbyte[1:0];
                `OFF_ACTION: nxt_st.action = wbyte;
                `OFF_ROT: nxt_st.rot = wbyte;
                `OFF_RAMP: nxt_st.ramp = wbyte;
                `OFF_IRQ_STAT: nxt_st.irq_stat = st_ff.irq_stat & ~wbyte[2:0];
                `OFF_IRQ_MASK: nxt_st.irq_mask = wbyte[2:0];
                `OFF_XSTEPS: nxt_st.xsteps = wbyte;
                `OFF_PERIOD: nxt_st.period = wbyte;
                default: ;
            endcase
        end
        // motion phases
        unique case (st_ff.phase)
            PH_IDLE: begin
                if (wr_en && st_ff.wr_addr == `OFF_CTRL
                    && wbyte[`CTRL_RUN_BIT]) begin
                    nxt_st.dir = wbyte[`CTRL_DIR_BIT];
                    nxt_st.steps_left = rot_steps(st_ff.rot);
                    nxt_st.ramp_pos = st_ff.ramp;
                    nxt_st.phase = st_ff.cfg[`CFG_RUP_BIT] ?
                        PH_RAMP_UP : PH_RUN;
                end
            end
            PH_RAMP_UP: begin
                if (stop_req) begin
                    if (st_ff.cfg[`CFG_HARD_BIT]) begin
                        nxt_st.phase = PH_IDLE; // see R4
                    end else if (st_ff.cfg[`CFG_RDN_BIT]) begin
                        nxt_st.phase = PH_RAMP_DN; // see R5
                        nxt_st.ramp_pos = st_ff.ramp - st_ff.ramp_pos;
                    end else begin
                        nxt_st.phase = PH_IDLE; // see R6
                    end
                end else if (step_pulse) begin
                    // sensor edges fall through unused here, see R1 R3
                    if (st_ff.ramp_pos == 8'h00) begin
                        nxt_st.phase = PH_RUN; // see R2
                    end else begin
                        nxt_st.ramp_pos = st_ff.ramp_pos - 8'h01;
                    end
                end
            end
            PH_RUN, PH_XSTEP: begin
                if (stop_req) begin
                    nxt_st.phase = st_ff.cfg[`CFG_RDN_BIT] &&
                        !st_ff.cfg[`CFG_HARD_BIT] ? PH_RAMP_DN : PH_IDLE;
                    nxt_st.ramp_pos = 8'h00;
                end else if (sense_any && st_ff.phase == PH_RUN &&
                    st_ff.action[`ACT_REV_BIT]) begin // see R2 R9
                    if (st_ff.action[`ACT_XSTEP_BIT]) begin
                        nxt_st.phase = PH_XSTEP; // see R12
                        nxt_st.xleft = st_ff.xsteps;
                    end else begin
                        nxt_st.dir = !st_ff.dir; // see R10
                        nxt_st.steps_left = rot_steps(st_ff.rot); // see R17
                    end
                end else if (st_ff.phase == PH_XSTEP && step_pulse) begin
                    if (st_ff.xleft <= 8'h01) begin
                        nxt_st.phase = PH_RUN;
                        nxt_st.dir = !st_ff.dir; // see R12
                        nxt_st.steps_left = rot_steps(st_ff.rot); // see R17
                    end else begin
                        nxt_st.xleft = st_ff.xleft - 8'h01;
                    end
                end else if (step_pulse) begin
                    if (st_ff.steps_left <= 16'h0001) begin
                        nxt_st.ramp_pos = 8'h00;
                        nxt_st.phase = st_ff.cfg[`CFG_RDN_BIT] ?
                            PH_RAMP_DN : PH_IDLE; // see R11
                    end else begin
                        nxt_st.steps_left = st_ff.steps_left - 16'h0001;
                    end
                end
            end
            PH_RAMP_DN: begin
                if (stop_req && st_ff.cfg[`CFG_HARD_BIT]) begin
                    nxt_st.phase = PH_IDLE; // see R7
                end else if (step_pulse) begin
                    // a soft stop leaves the ramp running, see R8
                    if (st_ff.ramp_pos >= st_ff.ramp) begin
                        nxt_st.phase = PH_IDLE;
                    end else begin
                        nxt_st.ramp_pos = st_ff.ramp_pos + 8'h01;
                    end
                end
            end
            default: nxt_st.phase = PH_IDLE;
        endcase
        // run bit cleared whenever the next phase is idle
        if (nxt_st.phase == PH_IDLE) begin
            nxt_st.ctrl[`CTRL_RUN_BIT] = 1'b0;
        end
        // coil sequence advances on every step outside idle
        if (step_pulse && st_ff.phase != PH_IDLE) begin
            nxt_st.seq = st_ff.dir ? st_ff.seq - 3'h1 : st_ff.seq + 3'h1;
        end
        nxt_st.coils = st_ff.phase == PH_IDLE ? 4'h0 : coil_map(st_ff.seq);
        // sticky events, set wins over a clearing write
        if (sense_any && st_ff.phase != PH_IDLE) begin
            if (st_ff.phase == PH_RAMP_UP || st_ff.phase == PH_RAMP_DN) begin
                nxt_st.irq_stat[`IRQ_IGN_BIT] = 1'b1; // see R1
            end else begin
                nxt_st.irq_stat[`IRQ_SENSE_BIT] = 1'b1;
            end
        end
        if (st_ff.phase != PH_IDLE && nxt_st.phase == PH_IDLE) begin
            nxt_st.irq_stat[`IRQ_STOP_BIT] = 1'b1;
        end
    end

    // **************************************************
    // registers and outputs
    // **************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= '0;
            st_ff.rot <= `RST_ROT;
            st_ff.ramp <= `RST_RAMP;
            st_ff.xsteps <= `RST_XSTEPS;
            st_ff.period <= `RST_PERIOD;
            st_ff.phase <= PH_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    step_timer u_step_timer (
        .hclk(hclk),
        .hresetn(hresetn),
        .enable(st_ff.phase != PH_IDLE),
        .period(step_period),
        .step_pulse(step_pulse)
    );

    assign ahb_rsp.hrdata = st_ff.rdata;
    assign ahb_rsp.hreadyout = 1'b1; // zero wait states
    assign ahb_rsp.hresp = 1'b0;
    assign phase_out = st_ff.coils;
    assign irq = |(st_ff.irq_stat & st_ff.irq_mask);
endmodule // motor_ctl

// *** tb/motor_ctl_assertions.sv ***
// checker for the stepper ramp / stop / sensor priority block
// assumes the top ports of motor_ctl and the register offsets
`timescale 1ns/1ps
`include "motor_ctl_defs.svh"
module motor_ctl_assertions (
    input wire logic hclk,
    input wire logic hresetn,
    input wire motor_ctl_pkg::ahb_req_t ahb_req,
    input wire logic [31:0] hwdata,
    input wire motor_ctl_pkg::ahb_rsp_t ahb_rsp,
    input wire logic sense_input_0,
    input wire logic sense_input_1,
    input wire logic [3:0] phase_out,
    input wire logic irq
);
    import motor_ctl_pkg::*;
    // ******************************
    // bus tracking helpers
    // ******************************
    logic taken;
    logic stop_w;
    logic dph_ff;
    logic wr_ff;
    logic [11:0] adr_ff;
    logic [7:0] cfg_ff;
    logic [7:0] msk_ff;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // a transfer is taken when selected, non-idle and ready
    assign taken = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready;
    assign stop_w = dph_ff && wr_ff && adr_ff == `OFF_CTRL
        && !hwdata[`CTRL_RUN_BIT];
    // shadow of the config and irq mask bytes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_ff <= 1'b0;
            wr_ff <= 1'b0;
            adr_ff <= 12'h000;
            cfg_ff <= 8'h00;
            msk_ff <= 8'h00;
        end else begin
            dph_ff <= taken;
            wr_ff <= ahb_req.hwrite;
            adr_ff <= ahb_req.haddr[11:0];
            if (dph_ff && wr_ff && adr_ff == `OFF_CFG) cfg_ff <= hwdata[7:0];
            if (dph_ff && wr_ff && adr_ff == `OFF_IRQ_MASK) begin
                msk_ff <= hwdata[7:0];
            end
        end
    end
    bus_okay_a: assert property (ahb_rsp.hreadyout && !ahb_rsp.hresp)
        else $error("bus answer not ready or not okay");
    lane_zero_a: assert property (ahb_rsp.hrdata[31:8] == 24'h000000)
        else $error("read data outside the low byte");
    rdata_hold_a: assert property (!$past(taken && !ahb_req.hwrite) |->
        $stable(ahb_rsp.hrdata)) else $error("read data moved without a read");
    idle_after_rst_a: assert property ($rose(hresetn) |->
        phase_out == 4'h0 && !irq) else $error("outputs busy after reset");
    two_phase_a: assert property (phase_out != 4'h0 |->
        $countones(phase_out) == 2) else $error("coil pattern not two-phase");
    hard_halt_a: assert property (stop_w && cfg_ff[`CFG_HARD_BIT] |->
        ##4 (phase_out == 4'h0) [*4]) else $error("hard stop did not halt");
    halt_irq_a: assert property (stop_w && cfg_ff[`CFG_HARD_BIT] &&
        phase_out != 4'h0 && msk_ff[`IRQ_STOP_BIT] |-> ##[1:6] irq)
        else $error("stop flag not raised on hard stop");
    irq_masked_a: assert property (msk_ff == 8'h00 &&
        $past(msk_ff) == 8'h00 |-> !irq) else $error("irq with all masked");
    cover property (stop_w && cfg_ff[`CFG_HARD_BIT]);
    cover property ($rose(irq));
    cover property ($rose(sense_input_0));
endmodule // motor_ctl_assertions
bind motor_ctl motor_ctl_assertions chk_i (.hclk(hclk), .hresetn(hresetn),
    .ahb_req(ahb_req), .hwdata(hwdata), .ahb_rsp(ahb_rsp),
    .sense_input_0(sense_input_0), .sense_input_1(sense_input_1),
    .phase_out(phase_out), .irq(irq));

// *** tb/sensor_src.sv ***
// sensor model: clean logic-level pulses on the two sensor pins
// assumes the bench requests a pulse with a one-cycle fire strobe
`timescale 1ns/1ps
module sensor_src (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [1:0] fire,
    output logic [1:0] sense
);
    // ******************************
    // pulse stretchers
    // ******************************
    logic [2:0] cnt0_ff;
    logic [2:0] cnt1_ff;
    // each pulse is held four cycles, no glitches
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt0_ff <= 3'h0;
            cnt1_ff <= 3'h0;
        end else begin
            cnt0_ff <= fire[0] ? 3'h4 : cnt0_ff - {2'h0, cnt0_ff != 3'h0};
            cnt1_ff <= fire[1] ? 3'h4 : cnt1_ff - {2'h0, cnt1_ff != 3'h0};
        end
    end
    assign sense = {cnt1_ff != 3'h0, cnt0_ff != 3'h0};
endmodule // sensor_src

// *** tb/testbench.sv ***
// self-checking bench for motor_ctl over ahb-lite
// assumes motor_ctl_defs.svh on the include path
`timescale 1ns/1ps
`include "motor_ctl_defs.svh"
module testbench;
    import motor_ctl_pkg::*;
    // ******************************
    // signals and instances
    // ******************************
    logic hclk, hresetn, sel, wrq, irq;
    logic [1:0] trans, fire, sense;
    logic [31:0] addr, wdata, v;
    logic [3:0] phase_out;
    ahb_req_t req;
    ahb_rsp_t rsp;
    int err_count, checks_done;
    logic [11:0] offs [7] = '{`OFF_ROT, `OFF_RAMP, `OFF_XSTEPS, `OFF_PERIOD,
        `OFF_CFG, `OFF_STATUS, 12'h03C};
    logic [7:0] rvals [7] = '{`RST_ROT, `RST_RAMP, `RST_XSTEPS, `RST_PERIOD,
        8'h00, 8'h00, 8'h00};
    assign req = '{hsel: sel, haddr: addr, htrans: trans, hwrite: wrq,
        hsize: 3'h2, hready: rsp.hreadyout};
    motor_ctl dut (.hclk(hclk), .hresetn(hresetn), .ahb_req(req),
        .hwdata(wdata), .ahb_rsp(rsp), .sense_input_0(sense[0]),
        .sense_input_1(sense[1]), .phase_out(phase_out), .irq(irq));
    sensor_src far (.hclk(hclk), .hresetn(hresetn), .fire(fire),
        .sense(sense));
    // 25 MHz clock
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    // ******************************
    // tasks
    // ******************************
    task give_verdict;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp, input string s);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s got %h", $time, s, got);
        end
    endtask
    task ready_wait;
        int n;
        n = 0;
        @(posedge hclk);
        while (rsp.hreadyout !== 1'b1 && n < 100) begin
            n++;
            @(posedge hclk);
        end
        if (n >= 100) begin
            chk(32'h0, 32'h1, "bus hang");
            give_verdict;
        end
    endtask
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        sel <= 1'b1;
        addr <= {20'h00000, a};
        trans <= 2'h2;
        wrq <= w;
        ready_wait;
        sel <= 1'b0;
        trans <= 2'h0;
        wdata <= d;
        ready_wait;
        v = rsp.hrdata;
    endtask
    task rchk(input logic [11:0] a, input logic [31:0] e, input string s);
        bus(1'b0, a, 32'h0);
        chk(v, e, s);
    endtask
    // one more edge so the block has seen the new sensor level on return
    task pulse(input logic [1:0] f);
        fire <= f;
        @(posedge hclk);
        fire <= 2'h0;
        @(posedge hclk);
    endtask
    task wait_ph(input logic [2:0] p);
        int n;
        n = 0;
        do begin
            bus(1'b0, `OFF_STATUS, 32'h0);
            n++;
        end while (v[2:0] !== p && n < 3000);
        chk({29'h0, v[2:0]}, {29'h0, p}, "phase wait");
        if (v[2:0] !== p) give_verdict;
    endtask
    // start in ramp-up, ignore a sensor, then stop
    task stop_case(input logic [7:0] c, input logic [31:0] e);
        bus(1'b1, `OFF_CFG, {24'h0, c});
        bus(1'b1, `OFF_CTRL, 32'h80);
        rchk(`OFF_STATUS, 32'h1, "ramp-up entered");
        pulse(2'h1);
        rchk(`OFF_STATUS, 32'h1, "sensor in ramp-up");
        bus(1'b1, `OFF_CTRL, 32'h00);
        rchk(`OFF_STATUS, e, "phase after stop");
    endtask
    // ******************************
    // main sequence
    // ******************************
    initial begin
        {sel, wrq, hresetn, trans, fire, addr, wdata, v} = '0;
        err_count = 0;
        checks_done = 0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 7; i++) begin
            rchk(offs[i], {24'h0, rvals[i]}, "reset");
        end
        bus(1'b1, `OFF_CFG, 32'hFFFFFF05);
        rchk(`OFF_CFG, 32'h05, "byte write");
        bus(1'b1, `OFF_STATUS, 32'h07);
        rchk(`OFF_STATUS, 32'h0, "status read-only");
        $display("test registers done");
        bus(1'b1, `OFF_IOC, 32'h03);
        bus(1'b1, `OFF_MASK_IN, 32'h03);
        bus(1'b1, `OFF_EDGE_R, 32'h03);
        bus(1'b1, `OFF_ACTION, 32'h01);
        bus(1'b1, `OFF_IRQ_MASK, 32'h02);
        stop_case(8'h07, 32'h0);
        chk({28'h0, phase_out}, 32'h0, "coils after hard stop");
        rchk(`OFF_IRQ_STAT, 32'h06, "stop and ignore flags");
        chk({31'h0, irq}, 32'h1, "irq raised");
        bus(1'b1, `OFF_IRQ_STAT, 32'h07);
        rchk(`OFF_IRQ_STAT, 32'h0, "flags cleared");
        chk({31'h0, irq}, 32'h0, "irq cleared");
        stop_case(8'h02, 32'h0);
        stop_case(8'h06, 32'h4);
        bus(1'b1, `OFF_CTRL, 32'h00);
        rchk(`OFF_STATUS, 32'h4, "stop in ramp-down");
        bus(1'b1, `OFF_CFG, 32'h07);
        bus(1'b1, `OFF_CTRL, 32'h00);
        rchk(`OFF_STATUS, 32'h0, "hard stop in ramp-down");
        $display("test stop priority done");
        bus(1'b1, `OFF_CFG, 32'h06);
        bus(1'b1, `OFF_RAMP, 32'h01);
        bus(1'b1, `OFF_PERIOD, 32'h01);
        bus(1'b1, `OFF_ROT, 32'h04);
        bus(1'b1, `OFF_XSTEPS, 32'h40);
        bus(1'b1, `OFF_IRQ_STAT, 32'h07);
        bus(1'b1, `OFF_IRQ_MASK, 32'h01);
        bus(1'b1, `OFF_CTRL, 32'h80);
        wait_ph(3'h2);
        bus(1'b1, `OFF_MASK_IN, 32'h02);
        pulse(2'h1);
        rchk(`OFF_STATUS, 32'h2, "masked pin ignored");
        chk({31'h0, irq}, 32'h0, "no irq from masked pin");
        bus(1'b1, `OFF_MASK_IN, 32'h03);
        pulse(2'h1);
        rchk(`OFF_STATUS, 32'hA, "reverse at speed");
        chk({31'h0, irq}, 32'h1, "sense irq");
        bus(1'b1, `OFF_IRQ_STAT, 32'h01);
        @(posedge hclk);
        chk({31'h0, irq}, 32'h0, "sense irq cleared");
        bus(1'b1, `OFF_ACTION, 32'h03);
        pulse(2'h2);
        rchk(`OFF_STATUS, 32'hB, "extra steps first");
        wait_ph(3'h2);
        rchk(`OFF_STATUS, 32'h2, "reversed after steps");
        wait_ph(3'h4);
        wait_ph(3'h0);
        $display("test sensor actions done");
        give_verdict;
    end
endmodule // testbench
